// ### hw/gpmp_cfg_if.sv
// interface: per-pin trigger configuration from registers to detector
`timescale 1ns/1ps
interface gpmp_cfg_if;
    logic [7:0] sense;
    logic [7:0] both;
    logic [7:0] event_pol;
    logic [7:0] clear;
    logic [7:0] raw;
    modport regs (output sense, output both, output event_pol,
                  output clear, input raw);
    modport det  (input sense, input both, input event_pol,
                  input clear, output raw);
endinterface

// ### hw/gpmp_irq_det.sv
// module: per-pin edge/level trigger detection and raw status latch
`timescale 1ns/1ps
module gpmp_irq_det
    import gpmp_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic [GPMP_W-1:0] i_pin,
    gpmp_cfg_if.det                cfg
);
    logic [GPMP_W-1:0] prev;
    logic [GPMP_W-1:0] raw_edge;
    wire  [GPMP_W-1:0] rise = i_pin & ~prev;
    wire  [GPMP_W-1:0] fall = ~i_pin & prev;
    // polarity 1 picks rising/high, 0 falling/low
    // both-edge choice is per pin, never a whole-port switch
    wire  [GPMP_W-1:0] sel_edge = (cfg.both & (rise | fall))
        | (~cfg.both & ((rise & cfg.event_pol) | (fall & ~cfg.event_pol)));
    wire  [GPMP_W-1:0] lvl_hit = ~(i_pin ^ cfg.event_pol);
    wire  [GPMP_W-1:0] edge_hit = sel_edge & ~cfg.sense;

    // edge hits latch; a hit in the clear cycle wins over the clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prev     <= RST_ZERO;
            raw_edge <= RST_ZERO;
        end else begin
            prev     <= i_pin;
            raw_edge <= (raw_edge & ~cfg.clear) | edge_hit; // RL9
        end
    end

    // level sources follow the pin; the source must hold it
    assign cfg.raw = (raw_edge & ~cfg.sense)
                   | (lvl_hit & cfg.sense); // RL11
endmodule

// ### hw/gpmp_pkg.sv
// package: register map, reset values and field constants of the gpio port
package gpmp_pkg;
    localparam int          GPMP_W          = 8;
    localparam int          GPMP_AW         = 12;
    localparam logic [11:0] OFS_DATA_LAST   = 12'h03FC;
    localparam logic [11:0] OFS_DIR         = 12'h0400;
    localparam logic [11:0] OFS_IRQ_SENSE   = 12'h0404;
    localparam logic [11:0] OFS_IRQ_BOTH    = 12'h0408;
    localparam logic [11:0] OFS_IRQ_EVENT   = 12'h040C;
    localparam logic [11:0] OFS_IRQ_MASK    = 12'h0410;
    localparam logic [11:0] OFS_IRQ_RAW     = 12'h0414;
    localparam logic [11:0] OFS_IRQ_MSTAT   = 12'h0418;
    localparam logic [11:0] OFS_IRQ_CLEAR   = 12'h041C;
    localparam logic [11:0] OFS_ALT_SEL     = 12'h0420;
    localparam logic [11:0] OFS_DRV_LOW     = 12'h0500;
    localparam logic [11:0] OFS_DRV_MID     = 12'h0504;
    localparam logic [11:0] OFS_DRV_HIGH    = 12'h0508;
    localparam logic [11:0] OFS_OPEN_DRAIN  = 12'h050C;
    localparam logic [11:0] OFS_PULL_UP     = 12'h0510;
    localparam logic [11:0] OFS_PULL_DOWN   = 12'h0514;
    localparam logic [11:0] OFS_SLEW        = 12'h0518;
    localparam logic [11:0] OFS_DIG_EN      = 12'h051C;
    localparam logic [11:0] OFS_PERIPH_ID0  = 12'h0FD0;
    localparam logic [11:0] OFS_PERIPH_ID7  = 12'h0FEC;
    localparam logic [11:0] OFS_CELL_ID0    = 12'h0FF0;
    localparam logic [11:0] OFS_CELL_ID3    = 12'h0FFC;
    localparam int          DATA_MASK_LSB   = 2;
    localparam int          ID_IDX_LSB      = 2;
    localparam logic [7:0]  RST_ZERO        = 8'h00;
    localparam logic [7:0]  RST_ONES        = 8'hFF;
    localparam logic [7:0]  RST_DRV_LOW     = 8'hFF;
    localparam logic [7:0]  RST_PULL_UP     = 8'hFF;
    localparam logic [7:0]  RST_DIG_EN      = 8'hFF;
    // identification bytes: values arbitrary, chosen for this block
    localparam logic [7:0]  ID_PERIPH [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                              8'h5A, 8'h01, 8'h10, 8'h00};
    localparam logic [7:0]  ID_CELL   [4] = '{8'h0D, 8'hF0, 8'h05, 8'hB1};
endpackage

// ### hw/gpmp_port.sv
// module: one eight-pin gpio port with masked data access and interrupts
`timescale 1ns/1ps
// Behaviour
// RL1: address bits nine to two mask data
// RL2: masked write changes only selected bits
// RL3: masked read returns zero for unselected bits
// RL4: ordinary pins reset as software inputs
// RL5: test-port pins reset to alternate function
// RL6: power-on and external reset restore defaults
// RL7: direction register bit per pin
// RL8: all pin conditions merge into one interrupt
// RL9: edge condition latched until software clears
// RL10: level source holds level until recognised
// RL11: sense, both-edges, polarity choose trigger
// RL12: mask bit forwards pin condition
// RL13: raw shows all, masked shows forwarded
// RL14: write one clears latched condition
// RL15: mask pin before changing trigger settings
// RL16: alternate select hands pin to peripheral
// RL17: drive, slew, pulls, open drain, input enable
// RL18: read-only peripheral and cell identification
// RL19: each port is identical copy
// RL20: event one high/rising, sense one level
// RL21: unbonded bits ignore writes
// RL22: alternate mode ignores direction and data
// RL23: inputs synchronised before edge detection
module gpmp_port
    import gpmp_pkg::*;
#(
    parameter logic [7:0] BONDED_PINS = 8'hFF, // RL19
    parameter logic [7:0] ALT_RESET   = 8'h00
)(
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire logic [GPMP_AW-1:0] i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [31:0]        o_rdata,
    input  wire logic [GPMP_W-1:0]  i_pin,
    output logic      [GPMP_W-1:0]  o_pin,
    output logic      [GPMP_W-1:0]  o_pin_oe,
    input  wire logic [GPMP_W-1:0]  i_alt_out,
    input  wire logic [GPMP_W-1:0]  i_alt_oe,
    output logic      [GPMP_W-1:0]  o_alt_in,
    output logic      [GPMP_W-1:0]  o_drive_low,
    output logic      [GPMP_W-1:0]  o_drive_mid,
    output logic      [GPMP_W-1:0]  o_drive_high,
    output logic      [GPMP_W-1:0]  o_slew,
    output logic      [GPMP_W-1:0]  o_pull_up,
    output logic      [GPMP_W-1:0]  o_pull_down,
    output logic      [GPMP_W-1:0]  o_open_drain,
    output logic      [GPMP_W-1:0]  o_dig_en,
    output logic                    o_irq
);
    // software-visible registers, then the pad sync, read mux and interrupt status signals
    logic [GPMP_W-1:0] port_data_reg;
    logic [GPMP_W-1:0] pin_direction_reg;
    logic [GPMP_W-1:0] alt_function_select;
    logic [GPMP_W-1:0] irq_sense_select;
    logic [GPMP_W-1:0] irq_both_edges_select;
    logic [GPMP_W-1:0] irq_event_polarity;
    logic [GPMP_W-1:0] irq_mask_enable;
    logic [GPMP_W-1:0] drive_low_select;
    logic [GPMP_W-1:0] drive_mid_select;
    logic [GPMP_W-1:0] drive_high_select;
    logic [GPMP_W-1:0] slew_select;
    logic [GPMP_W-1:0] pull_up_select;
    logic [GPMP_W-1:0] pull_down_select;
    logic [GPMP_W-1:0] open_drain_select;
    logic [GPMP_W-1:0] digital_input_enable;
    logic [GPMP_W-1:0] pin_sync;
    logic [GPMP_W-1:0] next_read;
    logic [GPMP_W-1:0] irq_raw_status;
    logic [GPMP_W-1:0] irq_masked_status;

    gpmp_cfg_if cfg ();

    // bit lane of a write that touches only bonded pins
    function automatic logic [GPMP_W-1:0] merge(
        input logic [GPMP_W-1:0] old_v,
        input logic [GPMP_W-1:0] new_v,
        input logic [GPMP_W-1:0] sel
    );
        logic [GPMP_W-1:0] en;
        en    = sel & BONDED_PINS;
        merge = (old_v & ~en) | (new_v & en); // RL21
    endfunction

    // address decode
    wire               is_data   = (i_addr <= OFS_DATA_LAST);
    wire  [GPMP_W-1:0] addr_mask =
        i_addr[DATA_MASK_LSB +: GPMP_W]; // RL1
    wire  [GPMP_W-1:0] wbyte     = i_wdata[GPMP_W-1:0];
    wire               wr_data   = i_wr && is_data;
    wire               wr_dir    = i_wr && (i_addr == OFS_DIR);
    wire               wr_sense  = i_wr && (i_addr == OFS_IRQ_SENSE);
    wire               wr_both   = i_wr && (i_addr == OFS_IRQ_BOTH);
    wire               wr_event  = i_wr && (i_addr == OFS_IRQ_EVENT);
    wire               wr_mask   = i_wr && (i_addr == OFS_IRQ_MASK);
    wire               wr_clear  = i_wr && (i_addr == OFS_IRQ_CLEAR);
    wire               wr_alt    = i_wr && (i_addr == OFS_ALT_SEL);
    wire               wr_dlow   = i_wr && (i_addr == OFS_DRV_LOW);
    wire               wr_dmid   = i_wr && (i_addr == OFS_DRV_MID);
    wire               wr_dhigh  = i_wr && (i_addr == OFS_DRV_HIGH);
    wire               wr_odr    = i_wr && (i_addr == OFS_OPEN_DRAIN);
    wire               wr_pu     = i_wr && (i_addr == OFS_PULL_UP);
    wire               wr_pd     = i_wr && (i_addr == OFS_PULL_DOWN);
    wire               wr_slr    = i_wr && (i_addr == OFS_SLEW);
    wire               wr_den    = i_wr && (i_addr == OFS_DIG_EN);
    wire               is_pid    = (i_addr >= OFS_PERIPH_ID0)
                                && (i_addr <= OFS_PERIPH_ID7);
    wire               is_cid    = (i_addr >= OFS_CELL_ID0)
                                && (i_addr <= OFS_CELL_ID3);
    wire  [2:0]        pid_idx   = 3'(i_addr[ID_IDX_LSB +: 3]);
    wire  [1:0]        cid_idx   = 2'(i_addr[ID_IDX_LSB +: 2]);

    // pad synchroniser ahead of edge detection and data reads
    gpmp_sync u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_pin),
        .o_sync  (pin_sync)
    ); // RL23

    // trigger config to the detector
    assign cfg.sense     = irq_sense_select;
    assign cfg.both      = irq_both_edges_select;
    assign cfg.event_pol = irq_event_polarity; // RL20
    assign cfg.clear     = wr_clear ? (wbyte & BONDED_PINS)
                                    : RST_ZERO; // RL14

    gpmp_irq_det u_det (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_pin (pin_sync),
        .cfg   (cfg.det)
    );

    // raw status regardless of mask; masked feeds the single output
    assign irq_raw_status    = cfg.raw & BONDED_PINS; // RL13
    assign irq_masked_status = irq_raw_status & irq_mask_enable; // RL12
    assign o_irq             = |irq_masked_status; // RL8

    // data and direction: data writes honour the address mask
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            port_data_reg     <= RST_ZERO;
            pin_direction_reg <= RST_ZERO; // RL4
        end else begin
            if (wr_data)
                port_data_reg <= merge(port_data_reg, wbyte,
                                       addr_mask); // RL2
            if (wr_dir)
                pin_direction_reg <= merge(pin_direction_reg, wbyte,
                                           RST_ONES); // RL7
        end
    end

    // alternate select: test-port pins come up owned by the peripheral;
    // the async reset covers both power-on and external reset sources
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            alt_function_select <= ALT_RESET; // RL5 RL6
        else if (wr_alt)
            alt_function_select <= merge(alt_function_select, wbyte,
                                         RST_ONES);
    end

    // trigger and mask registers; software masks before changing them
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_sense_select      <= RST_ZERO;
            irq_both_edges_select <= RST_ZERO;
            irq_event_polarity    <= RST_ZERO;
            irq_mask_enable       <= RST_ZERO;
        end else begin
            if (wr_sense)
                irq_sense_select <= merge(irq_sense_select, wbyte,
                                          RST_ONES); // RL11
            if (wr_both)
                irq_both_edges_select <= merge(irq_both_edges_select,
                                               wbyte, RST_ONES);
            if (wr_event)
                irq_event_polarity <= merge(irq_event_polarity, wbyte,
                                            RST_ONES);
            if (wr_mask)
                irq_mask_enable <= merge(irq_mask_enable, wbyte,
                                         RST_ONES);
        end
    end

    // drive strength: the three selects are mutually exclusive,
    // so writing one drops that pin from the other two
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            drive_low_select  <= RST_DRV_LOW;
            drive_mid_select  <= RST_ZERO;
            drive_high_select <= RST_ZERO;
        end else if (wr_dlow | wr_dmid | wr_dhigh) begin
            drive_low_select  <= wr_dlow ?
                merge(drive_low_select, wbyte, RST_ONES) :
                merge(drive_low_select, RST_ZERO, wbyte); // RL17
            drive_mid_select  <= wr_dmid ?
                merge(drive_mid_select, wbyte, RST_ONES) :
                merge(drive_mid_select, RST_ZERO, wbyte);
            drive_high_select <= wr_dhigh ?
                merge(drive_high_select, wbyte, RST_ONES) :
                merge(drive_high_select, RST_ZERO, wbyte);
        end
    end

    // remaining pad options; pull-up and pull-down also exclude
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pull_up_select       <= RST_PULL_UP;
            pull_down_select     <= RST_ZERO;
            open_drain_select    <= RST_ZERO;
            slew_select          <= RST_ZERO;
            digital_input_enable <= RST_DIG_EN;
        end else begin
            if (wr_pu) begin
                pull_up_select   <= merge(pull_up_select, wbyte, RST_ONES);
                pull_down_select <= merge(pull_down_select, RST_ZERO,
                                          wbyte);
            end else if (wr_pd) begin
                pull_down_select <= merge(pull_down_select, wbyte,
                                          RST_ONES);
                pull_up_select   <= merge(pull_up_select, RST_ZERO, wbyte);
            end
            if (wr_odr)
                open_drain_select <= merge(open_drain_select, wbyte,
                                           RST_ONES);
            if (wr_slr)
                slew_select <= merge(slew_select, wbyte, RST_ONES);
            if (wr_den)
                digital_input_enable <= merge(digital_input_enable, wbyte,
                                              RST_ONES);
        end
    end

    // pad controls; slew only takes effect at the strongest drive
    assign o_drive_low  = drive_low_select;
    assign o_drive_mid  = drive_mid_select;
    assign o_drive_high = drive_high_select;
    assign o_slew       = slew_select & drive_high_select; // RL17
    assign o_pull_up    = pull_up_select;
    assign o_pull_down  = pull_down_select;
    assign o_open_drain = open_drain_select;
    assign o_dig_en     = digital_input_enable;

    // pin mux: peripheral owns pin outright when selected
    wire [GPMP_W-1:0] sw_oe  = pin_direction_reg & ~alt_function_select;
    wire [GPMP_W-1:0] hw_oe  = i_alt_oe & alt_function_select; // RL22
    wire [GPMP_W-1:0] drv_v  = (alt_function_select & i_alt_out)
                             | (~alt_function_select & port_data_reg);
    wire [GPMP_W-1:0] any_oe = (sw_oe | hw_oe) & BONDED_PINS; // RL16
    // open drain: drive only lows, release for a high
    assign o_pin    = drv_v & ~open_drain_select;
    assign o_pin_oe = any_oe & ~(open_drain_select & drv_v);
    // input buffer off reads as zero
    wire [GPMP_W-1:0] pin_in = pin_sync & digital_input_enable;
    assign o_alt_in = pin_in & alt_function_select;

    // data read: outputs show latch, inputs show the pad
    wire [GPMP_W-1:0] data_view = (pin_direction_reg & port_data_reg)
                                | (~pin_direction_reg & pin_in);

    // read mux, one word per register outside the masked data window, unmapped reads zero
    always_comb begin
        next_read = RST_ZERO;
        if (is_data)
            next_read = data_view & addr_mask; // RL3
        else if (i_addr == OFS_DIR)
            next_read = pin_direction_reg;
        else if (i_addr == OFS_IRQ_SENSE)
            next_read = irq_sense_select;
        else if (i_addr == OFS_IRQ_BOTH)
            next_read = irq_both_edges_select;
        else if (i_addr == OFS_IRQ_EVENT)
            next_read = irq_event_polarity;
        else if (i_addr == OFS_IRQ_MASK)
            next_read = irq_mask_enable;
        else if (i_addr == OFS_IRQ_RAW)
            next_read = irq_raw_status;
        else if (i_addr == OFS_IRQ_MSTAT)
            next_read = irq_masked_status;
        else if (i_addr == OFS_ALT_SEL)
            next_read = alt_function_select;
        else if (i_addr == OFS_DRV_LOW)
            next_read = drive_low_select;
        else if (i_addr == OFS_DRV_MID)
            next_read = drive_mid_select;
        else if (i_addr == OFS_DRV_HIGH)
            next_read = drive_high_select;
        else if (i_addr == OFS_OPEN_DRAIN)
            next_read = open_drain_select;
        else if (i_addr == OFS_PULL_UP)
            next_read = pull_up_select;
        else if (i_addr == OFS_PULL_DOWN)
            next_read = pull_down_select;
        else if (i_addr == OFS_SLEW)
            next_read = slew_select;
        else if (i_addr == OFS_DIG_EN)
            next_read = digital_input_enable;
        else if (is_pid)
            next_read = ID_PERIPH[pid_idx]; // RL18
        else if (is_cid)
            next_read = ID_CELL[cid_idx];
    end

    // read data registered, valid the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            o_rdata <= 32'h0000_0000;
        else if (i_rd)
            o_rdata <= {24'h00_0000, next_read};
    end
endmodule

// ### hw/gpmp_sync.sv
// module: two-flop synchroniser for the pad inputs
`timescale 1ns/1ps
module gpmp_sync
    import gpmp_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [GPMP_W-1:0] i_async,
    output logic      [GPMP_W-1:0] o_sync
);
    logic [GPMP_W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta   <= RST_ZERO;
            o_sync <= RST_ZERO;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// ### sim/gpmp_pad_model.sv
// pad model: resolves each pad from port, external source and pulls
`timescale 1ns/1ps
module gpmp_pad_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pu,
    input  wire logic [7:0] i_pd,
    input  wire logic [7:0] i_ext_val,
    input  wire logic [7:0] i_ext_en,
    output logic      [7:0] o_pad
);
    logic [7:0] float_pat = 8'h55;
    // an undriven pad with no pull wanders, so stale values never pass
    always @(posedge i_clk) begin
        float_pat <= ~float_pat;
    end
    // port drive wins, then the held external level, then the pulls
    assign o_pad = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
                 | (~i_oe & ~i_ext_en & (i_pu | (~i_pd & float_pat)));
endmodule

// ### sim/gpmp_port_monitor.sv
// checker: port-level properties of the gpio port
`timescale 1ns/1ps
module gpmp_port_monitor
    import gpmp_pkg::*;
(
    input wire logic               i_clk,
    input wire logic               i_rst,
    input wire logic [GPMP_AW-1:0] i_addr,
    input wire logic [31:0]        i_wdata,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire logic [31:0]        o_rdata,
    input wire logic [GPMP_W-1:0]  o_drive_high,
    input wire logic [GPMP_W-1:0]  o_slew,
    input wire logic [GPMP_W-1:0]  o_pull_up,
    input wire logic [GPMP_W-1:0]  o_pull_down,
    input wire logic               o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // read port: upper bits, masked data view, hold between reads
    hi_bits_zero_a: assert property (
        i_rd |=> o_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    data_mask_a: assert property (
        i_rd && i_addr[11:10] == 2'h0
        |=> (o_rdata[7:0] & ~$past(i_addr[9:2])) == 8'h00)
        else $error("masked data bit read as nonzero");
    rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata))
        else $error("read data moved without a read");
    // pad controls: slew only with strong drive, pulls never both
    slew_high_a: assert property ((o_slew & ~o_drive_high) == 8'h00)
        else $error("slew set without strong drive");
    pull_excl_a: assert property ((o_pull_up & o_pull_down) == 8'h00)
        else $error("pull up and pull down together");
    // interrupt line agrees with masked status, and dies when masked
    mstat_irq_a: assert property (
        i_rd && i_addr == OFS_IRQ_MSTAT
        |=> (o_rdata[7:0] != 8'h00) == $past(o_irq))
        else $error("masked status disagrees with irq line");
    mask_off_a: assert property (
        i_wr && i_addr == OFS_IRQ_MASK && i_wdata[7:0] == 8'h00 |=> !o_irq)
        else $error("irq active with all pins masked");
    // direction written then read back two cycles on
    dir_back_a: assert property (
        i_wr && i_addr == OFS_DIR ##1 !i_wr && !i_rd
        ##1 i_rd && i_addr == OFS_DIR
        |=> o_rdata[7:0] == $past(i_wdata[7:0], 3))
        else $error("direction readback wrong");
endmodule

// ### sim/gpmp_port_tb.sv
// testbench: register, pad and interrupt scenarios for the gpio port
`timescale 1ns/1ps
module gpmp_port_tb
    import gpmp_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_rst, i_wr, i_rd, o_irq;
    logic [11:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [7:0]  i_pin, o_pin, o_pin_oe, i_alt_out, i_alt_oe, o_alt_in;
    logic [7:0]  o_drive_high, o_slew, o_pull_up, o_pull_down;
    logic [7:0]  ext_val, ext_en;
    int          err_total = 0, checked = 0, cyc = 0;
    // port b style: pin seven belongs to the test port after reset
    gpmp_port #(.ALT_RESET(8'h80)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin),
        .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_alt_out(i_alt_out),
        .i_alt_oe(i_alt_oe), .o_alt_in(o_alt_in), .o_drive_low(),
        .o_drive_mid(), .o_drive_high(o_drive_high), .o_slew(o_slew),
        .o_pull_up(o_pull_up), .o_pull_down(o_pull_down),
        .o_open_drain(), .o_dig_en(), .o_irq(o_irq));
    gpmp_pad_model i_pads (
        .i_clk(i_clk), .i_out(o_pin), .i_oe(o_pin_oe), .i_pu(o_pull_up),
        .i_pd(o_pull_down), .i_ext_val(ext_val), .i_ext_en(ext_en),
        .o_pad(i_pin));
    // clock and hang guard
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    // read data stand from the cycle after the strobe until the next read
    task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(nm, o_rdata, e);
    endtask
    task automatic t_reset;
        rdc(OFS_DIR, 32'h0000_0000, "dir");
        rdc(OFS_ALT_SEL, 32'h0000_0080, "alt");
        rdc(OFS_PULL_UP, 32'h0000_00FF, "pull");
        rdc(OFS_IRQ_RAW, 32'h0000_0000, "raw");
        // first id word holds byte four; index wraps on address bits
        for (int i = 0; i < 8; i++) begin
            rdc(OFS_PERIPH_ID0 + 12'(4 * i),
                {24'h00_0000, ID_PERIPH[(i + 4) % 8]}, "pid");
        end
        for (int i = 0; i < 4; i++) begin
            rdc(OFS_CELL_ID0 + 12'(4 * i),
                {24'h00_0000, ID_CELL[i]}, "cid");
        end
        wr(OFS_CELL_ID0, 32'h0000_0000);
        rdc(OFS_CELL_ID0, {24'h00_0000, ID_CELL[0]}, "cid_ro");
        $display("test reset done");
    endtask
    task automatic t_data;
        wr(OFS_DIR, 32'h0000_00FF);
        wr(OFS_DATA_LAST, 32'h0000_0000);
        wr(12'h098, 32'h0000_00EB);
        rdc(OFS_DATA_LAST, 32'h0000_0022, "data");
        rdc(12'h0C4, 32'h0000_0020, "mread");
        chk("pin", {24'h00_0000, o_pin}, 32'h0000_0022);
        chk("oe", {24'h00_0000, o_pin_oe}, 32'h0000_007F);
        @(posedge i_clk);
        i_alt_out <= 8'hFF;
        i_alt_oe  <= 8'h80;
        @(posedge i_clk);
        #1;
        chk("altpin", {24'h00_0000, o_pin}, 32'h0000_00A2);
        chk("altoe", {24'h00_0000, o_pin_oe}, 32'h0000_00FF);
        $display("test data done");
    endtask
    task automatic t_input;
        @(posedge i_clk);
        i_alt_oe <= 8'h00;
        ext_en   <= 8'h7F;
        ext_val  <= 8'h25;
        wr(OFS_DIR, 32'h0000_0000);
        repeat (3) @(posedge i_clk);
        rdc(12'h1FC, 32'h0000_0025, "in");
        chk("altin", {24'h00_0000, o_alt_in}, 32'h0000_0080);
        wr(OFS_DIG_EN, 32'h0000_0000);
        rdc(12'h1FC, 32'h0000_0000, "den");
        wr(OFS_DIG_EN, 32'h0000_00FF);
        $display("test input done");
    endtask
    // trigger table on pin 0: sense, both, event, start level, raw
    task automatic t_modes;
        logic [4:0] tb [6] = '{5'h05, 5'h03, 5'h00, 5'h0B, 5'h15, 5'h13};
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_IRQ_SENSE, {31'h0, tb[i][4]});
            wr(OFS_IRQ_BOTH, {31'h0, tb[i][3]});
            wr(OFS_IRQ_EVENT, {31'h0, tb[i][2]});
            @(posedge i_clk);
            ext_val[0] <= tb[i][1];
            repeat (4) @(posedge i_clk);
            wr(OFS_IRQ_CLEAR, 32'h0000_00FF);
            @(posedge i_clk);
            ext_val[0] <= ~tb[i][1];
            repeat (4) @(posedge i_clk);
            rdc(OFS_IRQ_RAW, {31'h0, tb[i][0]}, "mode");
        end
        chk("masked", {31'h0, o_irq}, 32'h0000_0000);
        $display("test modes done");
    endtask
    task automatic t_edge;
        wr(OFS_IRQ_SENSE, 32'h0000_0000);
        wr(OFS_IRQ_EVENT, 32'h0000_0001);
        wr(OFS_IRQ_CLEAR, 32'h0000_00FF);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        @(posedge i_clk);
        ext_val[0] <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        chk("irq", {31'h0, o_irq}, 32'h0000_0001);
        rdc(OFS_IRQ_MSTAT, 32'h0000_0001, "mstat");
        wr(OFS_IRQ_CLEAR, 32'h0000_0000);
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        rdc(OFS_IRQ_RAW, 32'h0000_0001, "held");
        wr(OFS_IRQ_CLEAR, 32'h0000_0001);
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        rdc(OFS_IRQ_RAW, 32'h0000_0000, "clr");
        chk("irq_off", {31'h0, o_irq}, 32'h0000_0000);
        $display("test edge done");
    endtask
    task automatic t_rst;
        wr(OFS_DIR, 32'h0000_00FF);
        rdc(OFS_DIR, 32'h0000_00FF, "dirw");
        wr(OFS_ALT_SEL, 32'h0000_0000);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rdc(OFS_DIR, 32'h0000_0000, "dir2");
        rdc(OFS_ALT_SEL, 32'h0000_0080, "alt2");
        $display("test mid reset done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // reset, then the scenarios in order
    initial begin
        {i_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 46'h0};
        {i_alt_out, i_alt_oe, ext_val, ext_en} = 32'h0000_0000;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_data();
        t_input();
        t_modes();
        t_edge();
        t_rst();
        end_sim();
    end
endmodule
bind gpmp_port gpmp_port_monitor i_mon (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_slew(o_slew),
    .o_drive_high(o_drive_high), .o_pull_up(o_pull_up),
    .o_pull_down(o_pull_down), .o_irq(o_irq));
